// >>> rtl/fct_pkg.sv
/*
  Package for the four-channel counter/timer: register offsets, control word
  field positions, reset values, timing constants and carrier structs.
  Assumes a single 50 MHz clock and an AXI4-Lite register bus of 32 bits.
*/
package fct_pkg;

  localparam int unsigned FCT_CHANNELS = 4;
  localparam int unsigned FCT_ADDR_W = 6;

  // Register byte offsets
  localparam logic [5:0] FCT_OFF_CTRL0 = 6'h00;
  localparam logic [5:0] FCT_OFF_TC0 = 6'h04;
  localparam logic [5:0] FCT_OFF_CNT0 = 6'h08;
  localparam logic [5:0] FCT_CH_STRIDE = 6'h0c;
  localparam logic [5:0] FCT_OFF_VEC = 6'h30;
  localparam logic [5:0] FCT_OFF_ACK = 6'h34;
  localparam logic [5:0] FCT_OFF_RETI = 6'h38;
  localparam logic [5:0] FCT_OFF_STAT = 6'h3c;

  // Control word fields
  localparam int unsigned FCT_CW_IE = 7;
  localparam int unsigned FCT_CW_MODE = 6;
  localparam int unsigned FCT_CW_PRESC = 5;
  localparam int unsigned FCT_CW_EDGE = 4;
  localparam int unsigned FCT_CW_TRIG = 3;
  localparam int unsigned FCT_CW_TCF = 2;
  localparam int unsigned FCT_CW_SWRST = 1;

  localparam logic [7:0] FCT_CW_RESET = 8'h02;
  localparam logic [7:0] FCT_VEC_RESET = 8'h00;
  localparam logic [7:0] FCT_VEC_NONE = 8'hff;

  // Prescaler factors
  localparam int unsigned FCT_PRESC_LO = 16;
  localparam int unsigned FCT_PRESC_HI = 256;

  // AXI responses
  localparam logic [1:0] FCT_RESP_OKAY = 2'h0;
  localparam logic [1:0] FCT_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ie;
    logic timer;
    logic presc_hi;
    logic rising;
    logic trig_wait;
  } fct_cfg_type;

  typedef struct packed {
    logic [FCT_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } fct_wreq_type;

endpackage

// >>> rtl/fct_top.sv
/*
  Four-channel counter/timer with vectored, prioritized interrupts, reached
  over AXI4-Lite. Trigger inputs are taken as synchronous to mclk.
  Assumes one write and one read at most under way at a time.
*/
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module fct_top
  import fct_pkg::*;
#(
  parameter int unsigned NCH = FCT_CHANNELS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [fct_pkg::FCT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [fct_pkg::FCT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins
  input wire logic [3:0] count_trigger_input,
  output logic [2:0] zero_count_timeout_output,
  // Interrupt daisy chain
  input wire logic int_chain_in,
  output logic int_chain_out,
  output logic int_req
);
  import fct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture
  logic aw_held_r;
  logic w_held_r;
  fct_wreq_type wreq_r;
  logic wr_go;
  logic wr_err;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wreq_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wreq_r.addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wreq_r.data <= s_axi_wdata;
        wreq_r.strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FCT_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? FCT_RESP_SLVERR : FCT_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [NCH-1:0] wr_ctrl;
  logic [NCH-1:0] wr_tc;
  logic wr_vec;
  logic wr_ack;
  logic wr_reti;
  logic lane0;

  assign lane0 = wreq_r.strb[0];

  always_comb begin
    wr_ctrl = '0;
    wr_tc = '0;
    wr_vec = 1'b0;
    wr_ack = 1'b0;
    wr_reti = 1'b0;
    wr_err = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (wreq_r.addr == 6'(FCT_OFF_CTRL0 + 6'(i) * FCT_CH_STRIDE)) begin
        wr_ctrl[i] = wr_go && lane0;
        wr_err = 1'b0;
      end
      if (wreq_r.addr == 6'(FCT_OFF_TC0 + 6'(i) * FCT_CH_STRIDE)) begin
        wr_tc[i] = wr_go && lane0;
        wr_err = 1'b0;
      end
      if (wreq_r.addr == 6'(FCT_OFF_CNT0 + 6'(i) * FCT_CH_STRIDE)) begin
        wr_err = 1'b0;
      end
    end
    if (wreq_r.addr == FCT_OFF_VEC) begin
      wr_vec = wr_go && lane0;
      wr_err = 1'b0;
    end
    if (wreq_r.addr == FCT_OFF_RETI) begin
      wr_reti = wr_go;
      wr_err = 1'b0;
    end
    if (wreq_r.addr == FCT_OFF_ACK || wreq_r.addr == FCT_OFF_STAT) begin
      wr_err = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: shared free divider giving /16 and /256 enables
  logic [7:0] presc_r;
  logic tick16;
  logic tick256;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  assign tick16 = (presc_r[3:0] == 4'(FCT_PRESC_LO - 1));
  assign tick256 = (presc_r == 8'(FCT_PRESC_HI - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  fct_cfg_type cfg_r [NCH];
  logic [NCH-1:0] run_r;
  logic [NCH-1:0] tc_pend_r;
  logic [NCH-1:0] armed_r;
  logic [7:0] tc_r [NCH];
  logic [7:0] cnt_r [NCH];
  logic [NCH-1:0] trig_q_r;
  logic [NCH-1:0] zero_hit;
  logic [NCH-1:0] trig_edge;
  logic [2:0] zc_r;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic dec;
    logic pre;
    logic [7:0] wbyte;

    assign wbyte = wreq_r.data[7:0];
    assign trig_edge[g] = cfg_r[g].rising ? (count_trigger_input[g] && !trig_q_r[g])
                                          : (!count_trigger_input[g] && trig_q_r[g]);
    assign pre = cfg_r[g].presc_hi ? tick256 : tick16;
    assign dec = run_r[g] && (cfg_r[g].timer ? pre : trig_edge[g]);
    assign zero_hit[g] = dec && (cnt_r[g] == 8'h01);

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        trig_q_r[g] <= 1'b0;
      end else begin
        trig_q_r[g] <= count_trigger_input[g];
      end
    end

    // Control word decode; a write with the time-constant flag set routes the next write
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cfg_r[g] <= '0;
        tc_pend_r[g] <= 1'b0;
      end else if (wr_ctrl[g]) begin
        cfg_r[g].ie <= wbyte[FCT_CW_IE];
        cfg_r[g].timer <= wbyte[FCT_CW_MODE];
        cfg_r[g].presc_hi <= wbyte[FCT_CW_PRESC];
        cfg_r[g].rising <= wbyte[FCT_CW_EDGE];
        cfg_r[g].trig_wait <= wbyte[FCT_CW_TRIG];
        tc_pend_r[g] <= wbyte[FCT_CW_TCF];
      end else if (wr_tc[g]) begin
        tc_pend_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        tc_r[g] <= 8'h00;
      end else if (wr_tc[g] || (wr_ctrl[g] && tc_pend_r[g])) begin
        tc_r[g] <= wbyte; // 8'h00 counts 256
      end
    end

    // Run control: software reset stops; a time constant starts or arms
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        run_r[g] <= 1'b0;
        armed_r[g] <= 1'b0;
      end else if (wr_ctrl[g] && !tc_pend_r[g] && wbyte[FCT_CW_SWRST]) begin
        run_r[g] <= 1'b0;
        armed_r[g] <= 1'b0;
      end else if (wr_tc[g] || (wr_ctrl[g] && tc_pend_r[g])) begin
        if (cfg_r[g].timer && cfg_r[g].trig_wait) begin
          run_r[g] <= run_r[g];
          armed_r[g] <= !run_r[g];
        end else begin
          run_r[g] <= 1'b1;
        end
      end else if (armed_r[g] && trig_edge[g]) begin
        run_r[g] <= 1'b1;
        armed_r[g] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_r[g] <= 8'h00;
      end else if ((wr_tc[g] || (wr_ctrl[g] && tc_pend_r[g])) && !run_r[g]) begin
        cnt_r[g] <= wbyte;
      end else if (zero_hit[g]) begin
        cnt_r[g] <= tc_r[g];
      end else if (dec) begin
        cnt_r[g] <= cnt_r[g] - 8'h01;
      end
    end
  end

  // Timeout pulses exist for channels 0..2 only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zc_r <= 3'h0;
    end else begin
      zc_r <= zero_hit[2:0];
    end
  end
  assign zero_count_timeout_output = zc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: pending, in-service, priority and vector
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] insvc_r;
  logic [7:0] vbase_r;
  logic [NCH-1:0] grant;
  logic [NCH-1:0] svc_top;
  logic [NCH-1:0] ack_take;
  logic [7:0] ack_vec;
  logic ack_rd;

  // Highest-priority pending channel not blocked by service at equal or higher priority
  always_comb begin
    logic blocked;
    blocked = !int_chain_in;
    grant = '0;
    for (int i = 0; i < NCH; i++) begin
      if (insvc_r[i]) begin
        blocked = 1'b1;
      end else if (pend_r[i] && !blocked) begin
        grant[i] = 1'b1;
        blocked = 1'b1;
      end
    end
  end

  always_comb begin
    logic found;
    found = 1'b0;
    svc_top = '0;
    for (int i = 0; i < NCH; i++) begin
      if (insvc_r[i] && !found) begin
        svc_top[i] = 1'b1;
        found = 1'b1;
      end
    end
  end

  always_comb begin
    ack_vec = FCT_VEC_NONE;
    for (int i = 0; i < NCH; i++) begin
      if (grant[i]) begin
        ack_vec = {vbase_r[7:3], 2'(i), 1'b0};
      end
    end
  end

  assign ack_take = ack_rd ? grant : '0;
  assign int_req = |grant;
  assign int_chain_out = int_chain_in && (insvc_r == '0) && (pend_r == '0);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vbase_r <= FCT_VEC_RESET;
    end else if (wr_vec) begin
      vbase_r <= wreq_r.data[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (zero_hit[i] && cfg_r[i].ie) begin
          pend_r[i] <= 1'b1;
        end else if (ack_take[i] || (wr_ctrl[i] && !cfg_r[i].ie && !wreq_r.data[FCT_CW_IE])) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      insvc_r <= '0;
    end else begin
      insvc_r <= (insvc_r & ~(wr_reti ? svc_top : '0)) | ack_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_data;
  logic rd_err;

  assign s_axi_arready = !s_axi_rvalid;
  assign ack_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == FCT_OFF_ACK);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (s_axi_araddr == 6'(FCT_OFF_CTRL0 + 6'(i) * FCT_CH_STRIDE)) begin
        rd_data = {24'h0, cfg_r[i], tc_pend_r[i], !run_r[i], 1'b0};
        rd_err = 1'b0;
      end
      if (s_axi_araddr == 6'(FCT_OFF_TC0 + 6'(i) * FCT_CH_STRIDE)) begin
        rd_data = {24'h0, tc_r[i]};
        rd_err = 1'b0;
      end
      if (s_axi_araddr == 6'(FCT_OFF_CNT0 + 6'(i) * FCT_CH_STRIDE)) begin
        rd_data = {24'h0, cnt_r[i]};
        rd_err = 1'b0;
      end
    end
    if (s_axi_araddr == FCT_OFF_VEC) begin
      rd_data = {24'h0, vbase_r};
      rd_err = 1'b0;
    end
    if (s_axi_araddr == FCT_OFF_ACK) begin
      rd_data = {24'h0, ack_vec};
      rd_err = 1'b0;
    end
    if (s_axi_araddr == FCT_OFF_STAT) begin
      rd_data = {20'h0, armed_r, insvc_r, pend_r};
      rd_err = 1'b0;
    end
    if (s_axi_araddr == FCT_OFF_RETI) begin
      rd_err = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= FCT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? FCT_RESP_SLVERR : FCT_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_reload;
    @(posedge mclk) disable iff (rst)
    zero_hit[0] |=> cnt_r[0] == $past(tc_r[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload at zero");

  property p_zc;
    @(posedge mclk) disable iff (rst)
    zero_hit[1] |=> zero_count_timeout_output[1] ##1 !zero_count_timeout_output[1] || zero_hit[1];
  endproperty
  a_zc: assert property (p_zc) else $error("timeout pulse wrong");

  property p_irq_en;
    @(posedge mclk) disable iff (rst)
    $rose(pend_r[1]) |-> $past(cfg_r[1].ie) && $past(zero_hit[1]);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt without enable");

  property p_dec;
    @(posedge mclk) disable iff (rst)
    run_r[0] && !cfg_r[0].timer && !trig_edge[0] && !wr_tc[0] && !wr_ctrl[0] |=> $stable(cnt_r[0]);
  endproperty
  a_dec: assert property (p_dec) else $error("counter moved without trigger");

  property p_presc;
    @(posedge mclk) disable iff (rst)
    tick256 |-> tick16 ##1 !tick16 [*8];
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler ticks wrong");

  property p_prio;
    @(posedge mclk) disable iff (rst)
    grant[1] |-> !pend_r[0] && !insvc_r[0];
  endproperty
  a_prio: assert property (p_prio) else $error("priority violated");

  property p_vec;
    @(posedge mclk) disable iff (rst)
    grant[3] |-> ack_vec[2:1] == 2'h3 && ack_vec[7:3] == vbase_r[7:3];
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");

  property p_svc;
    @(posedge mclk) disable iff (rst)
    ack_take[3] && !zero_hit[3] |=> insvc_r[3] && !pend_r[3];
  endproperty
  a_svc: assert property (p_svc) else $error("acknowledge not recorded");

endmodule

// >>> verif/fct_far_model.sv
/*
  Far-side model of the counter/timer pins: trigger source, upstream end of
  the interrupt daisy chain, and a monitor of the zero-count pulses.
  Assumes it drives its outputs just after a rising edge of mclk.
*/
`timescale 1ns/1ns
module fct_far_model (
  // Clock
  input wire logic mclk,
  // Device pins
  input wire logic [2:0] zero_count_timeout_output,
  output logic [3:0] count_trigger_input,
  output logic int_chain_in
);
  int cyc = 0;
  int zc_n [3] = '{0, 0, 0};
  int zc_last [3] = '{0, 0, 0};
  int zc_gap [3] = '{0, 0, 0};

  initial begin
    count_trigger_input = 4'h0;
    int_chain_in = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse count and spacing in cycles per output
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 3; i++) begin
      if (zero_count_timeout_output[i] === 1'b1) begin
        zc_n[i] <= zc_n[i] + 1;
        zc_gap[i] <= cyc - zc_last[i];
        zc_last[i] <= cyc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One rising then one falling edge on each masked trigger
  task automatic pulse(input logic [3:0] m);
    @(posedge mclk);
    count_trigger_input <= count_trigger_input | m;
    repeat (3) @(posedge mclk);
    count_trigger_input <= count_trigger_input & ~m;
    repeat (3) @(posedge mclk);
  endtask

  task automatic chain(input logic v);
    @(posedge mclk);
    int_chain_in <= v;
  endtask
endmodule

// >>> verif/four_channel_counter_timer_test.sv
/*
  Self-checking bench for the four-channel counter/timer over AXI4-Lite.
  Assumes the far-side model drives triggers and the daisy-chain input.
*/
`timescale 1ns/1ns
module four_channel_counter_timer_test;
  import fct_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] awaddr;
  logic [5:0] araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] v_rd;
  logic [1:0] r_rd;
  logic awready, wready, bvalid, arready, rvalid, chain_out, int_req, chain_in;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] trig;
  logic [2:0] zco;
  int n_fail = 0;
  int checks_done = 0;
  int n;

  initial begin
    forever #10 mclk = ~mclk;
  end

  fct_top dut (
    .mclk(mclk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_trigger_input(trig), .zero_count_timeout_output(zco),
    .int_chain_in(chain_in), .int_chain_out(chain_out), .int_req(int_req)
  );

  fct_far_model far (
    .mclk(mclk), .zero_count_timeout_output(zco),
    .count_trigger_input(trig), .int_chain_in(chain_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic [1:0] exp);
    @(negedge mclk);
    chk({30'h0, int_req, chain_out}, {30'h0, exp});
  endtask

  function automatic logic [5:0] ra(input int ch, input logic [5:0] off);
    return off + 6'(ch) * FCT_CH_STRIDE;
  endfunction

  task automatic axi_wr_s(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_p, w_p, aw_t, w_t, b_t;
    logic [1:0] rsp;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(negedge mclk);
      aw_t = aw_p && (awready === 1'b1);
      w_t = w_p && (wready === 1'b1);
      @(posedge mclk);
      if (aw_t) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge mclk);
      b_t = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge mclk);
    end
    bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d);
    axi_wr_s(a, {24'h0, d}, 4'h1, FCT_RESP_OKAY);
  endtask

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge mclk);
      t = (arready === 1'b1);
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge mclk);
      t = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end
    rready <= 1'b0;
  endtask

  task automatic chk_reg(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(a, v, r);
    chk(v, exp);
    chk({30'h0, r}, {30'h0, FCT_RESP_OKAY});
  endtask

  task automatic wait_zc(input int ch, input int k);
    int n0;
    n0 = far.zc_n[ch];
    while (far.zc_n[ch] < n0 + k) begin
      @(negedge mclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    awaddr <= 6'h00;
    araddr <= 6'h00;
    wdata <= 32'h0;
    wstrb <= 4'h0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    chk_reg(FCT_OFF_CTRL0, {24'h0, FCT_CW_RESET});
    chk_reg(FCT_OFF_CNT0, 32'h0);
    chk_reg(FCT_OFF_VEC, {24'h0, FCT_VEC_RESET});
    chk_reg(FCT_OFF_STAT, 32'h0);
    // Counter mode, rising edge, constant 3
    axi_wr(FCT_OFF_CTRL0, 8'h14);
    chk_reg(FCT_OFF_CTRL0, 32'h16);
    axi_wr(FCT_OFF_TC0, 8'h03);
    chk_reg(FCT_OFF_CTRL0, 32'h10);
    chk_reg(FCT_OFF_CNT0, 32'h3);
    far.pulse(4'h1);
    chk_reg(FCT_OFF_CNT0, 32'h2);
    chk_reg(FCT_OFF_CNT0, 32'h2);
    far.pulse(4'h1);
    far.pulse(4'h1);
    chk(32'(far.zc_n[0]), 32'h1);
    chk_reg(FCT_OFF_CNT0, 32'h3);
    chk_reg(FCT_OFF_STAT, 32'h0);
    // Only byte lane 0 carries data; unaligned addresses are refused
    axi_wr_s(FCT_OFF_TC0, 32'h0000_0007, 4'h0, FCT_RESP_OKAY);
    chk_reg(FCT_OFF_TC0, 32'h3);
    axi_wr_s(FCT_OFF_TC0, 32'h5a5a_5a03, 4'hf, FCT_RESP_OKAY);
    chk_reg(FCT_OFF_TC0, 32'h3);
    axi_wr_s(6'h01, 32'h0000_00ff, 4'h1, FCT_RESP_SLVERR);
    axi_rd(6'h02, v_rd, r_rd);
    chk({30'h0, r_rd}, {30'h0, FCT_RESP_SLVERR});
    chk_reg(FCT_OFF_CNT0, 32'h3);
    // Falling edge only, byte zero counts 256
    axi_wr(ra(1, FCT_OFF_CTRL0), 8'h04);
    axi_wr(ra(1, FCT_OFF_TC0), 8'h00);
    far.pulse(4'h2);
    chk_reg(ra(1, FCT_OFF_CNT0), 32'hff);
    chk_reg(FCT_OFF_CNT0, 32'h3);
    // Software reset halts counting
    axi_wr(FCT_OFF_CTRL0, 8'h12);
    far.pulse(4'h1);
    chk_reg(FCT_OFF_CNT0, 32'h3);
    chk_reg(FCT_OFF_CTRL0, 32'h12);
    // Timer mode with both prescale factors
    axi_wr(ra(2, FCT_OFF_CTRL0), 8'h44);
    axi_wr(ra(2, FCT_OFF_TC0), 8'h02);
    wait_zc(2, 3);
    chk(32'(far.zc_gap[2]), 32'(FCT_PRESC_LO * 2));
    axi_wr(ra(2, FCT_OFF_CTRL0), 8'h02);
    axi_wr(ra(2, FCT_OFF_CTRL0), 8'h64);
    axi_wr(ra(2, FCT_OFF_TC0), 8'h01);
    wait_zc(2, 3);
    chk(32'(far.zc_gap[2]), 32'(FCT_PRESC_HI));
    // Timer armed until a falling trigger edge
    axi_wr(ra(2, FCT_OFF_CTRL0), 8'h02);
    axi_wr(ra(2, FCT_OFF_CTRL0), 8'h4c);
    axi_wr(ra(2, FCT_OFF_TC0), 8'h01);
    chk_reg(FCT_OFF_STAT, 32'h400);
    n = far.zc_n[2];
    repeat (300) @(posedge mclk);
    chk(32'(far.zc_n[2]), 32'(n));
    far.pulse(4'h4);
    repeat (40) @(posedge mclk);
    chk(32'(far.zc_n[2] > n), 32'h1);
    chk_reg(FCT_OFF_STAT, 32'h0);
    // Vectored, prioritized interrupts from channels 1 and 3
    axi_wr(FCT_OFF_VEC, 8'h40);
    axi_wr(ra(1, FCT_OFF_CTRL0), 8'h02);
    axi_wr(ra(1, FCT_OFF_CTRL0), 8'h94);
    axi_wr(ra(1, FCT_OFF_TC0), 8'h01);
    axi_wr(ra(3, FCT_OFF_CTRL0), 8'h94);
    axi_wr(ra(3, FCT_OFF_TC0), 8'h01);
    far.pulse(4'ha);
    chk_reg(FCT_OFF_STAT, 32'h00a);
    chk_irq(2'b10);
    far.chain(1'b0);
    chk_irq(2'b00);
    far.chain(1'b1);
    chk_reg(FCT_OFF_ACK, 32'h42);
    chk_reg(FCT_OFF_ACK, {24'h0, FCT_VEC_NONE});
    axi_wr(FCT_OFF_RETI, 8'h00);
    chk_reg(FCT_OFF_ACK, 32'h46);
    axi_wr(FCT_OFF_RETI, 8'h00);
    chk_reg(FCT_OFF_ACK, {24'h0, FCT_VEC_NONE});
    chk_irq(2'b01);
    // Reset in mid-run returns every channel to its idle state
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk_reg(FCT_OFF_STAT, 32'h0);
    chk_reg(ra(2, FCT_OFF_CTRL0), {24'h0, FCT_CW_RESET});
    chk_reg(FCT_OFF_VEC, {24'h0, FCT_VEC_RESET});
    close_out();
  end

  // Watchdog well beyond the expected run of about 1200 cycles
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule
